/* File: common/flash_por_map.vh */
// Constants for the serial flash power-up and reset state block
`ifndef FLASH_POR_MAP_VH
`define FLASH_POR_MAP_VH
`define CLK_MHZ               100
`define SUPPLY_TO_SELECT_US   70
`define PROG_ERASE_STARTUP_US 3000
`define SUPPLY_TO_SELECT_CYC  (`SUPPLY_TO_SELECT_US * `CLK_MHZ)
`define PROG_ERASE_STARTUP_CYC (`PROG_ERASE_STARTUP_US * `CLK_MHZ)
`define STARTUP_CNT_W         19
`define MODE_0                1'b0
`define MODE_3                1'b1
`define MODE_RESET            `MODE_3
`define PIN_IDLE              3'h7
`endif

/* File: hdl/pin_sync.v */
// Two-flop synchroniser for a group of asynchronous pins
module pin_sync
#(
    parameter             WIDTH     = 3,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
)
(
    input  wire             i_clk_sys,
    input  wire             i_nrst,
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_bit
            always @(posedge i_clk_sys or negedge i_nrst)
            begin
                if (!i_nrst)
                begin
                    stage1[g] <= RESET_VAL[g];
                    stage2[g] <= RESET_VAL[g];
                end
                else
                begin
                    stage1[g] <= i_async[g];
                    stage2[g] <= stage1[g];
                end
            end
        end
    endgenerate
    assign o_sync = stage2;
endmodule

/* File: hdl/flash_por_state.v */
// Power-on and reset state handling of the serial flash slave interface
`include "flash_por_map.vh"
module flash_por_state
#(
    parameter PROG_ERASE_STARTUP_CYC = `PROG_ERASE_STARTUP_CYC
)
(
    input  wire i_clk_sys,
    input  wire i_nrst,
    input  wire i_chip_select_n,
    input  wire i_serial_clock,
    input  wire i_serial_data_in,
    input  wire i_out_request,
    input  wire i_out_data,
    input  wire i_prog_erase_req,
    output reg  o_serial_data_out,
    output reg  o_serial_data_out_oe_n,
    output reg  o_clock_mode,
    output reg  o_standby,
    output reg  o_instr_start,
    output reg  o_instr_active,
    output reg  o_shift_strobe,
    output reg  o_shift_bit,
    output reg  o_prog_erase_allowed,
    output reg  o_prog_erase_go
);
    localparam ST_POR     = 2'b00;
    localparam ST_STANDBY = 2'b01;
    localparam ST_ACTIVE  = 2'b10;
    localparam [31:0] STARTUP_LAST_FULL = PROG_ERASE_STARTUP_CYC - 1;
    localparam [`STARTUP_CNT_W-1:0] STARTUP_LAST = STARTUP_LAST_FULL[`STARTUP_CNT_W-1:0];

    // Bit positions of the pins inside the synchroniser
    localparam PIN_CS  = 0;
    localparam PIN_SCK = 1;
    localparam PIN_SI  = 2;

    wire [2:0] pins_sync;
    reg  [1:0] state;
    reg  [1:0] next_state;
    reg        cs_q;
    reg        sck_q;
    reg  [`STARTUP_CNT_W-1:0] startup_cnt;
    reg        startup_done;
    reg        pe_pending;

    wire cs_s   = pins_sync[PIN_CS];
    wire sck_s  = pins_sync[PIN_SCK];
    wire si_s   = pins_sync[PIN_SI];
    wire cs_fall = cs_q & ~cs_s;
    wire cs_rise = ~cs_q & cs_s;
    wire sck_rise = ~sck_q & sck_s;

    // Accepted instruction start: select fall seen while idle in standby
    function opens_frame;
        input [1:0] st;
        input       fall;
        begin
            opens_frame = (st == ST_STANDBY) && fall;
        end
    endfunction

    // Inside an opened instruction with select still low
    function in_frame;
        input [1:0] st;
        input       cs_level;
        begin
            in_frame = (st == ST_ACTIVE) && !cs_level;
        end
    endfunction

    // Requests only heard once the reset state has been left
    function powered_up;
        input [1:0] st;
        begin
            powered_up = (st != ST_POR);
        end
    endfunction

    // Pins reset to idle high so no false select fall follows reset
    pin_sync #(.WIDTH(3), .RESET_VAL(`PIN_IDLE)) u_sync
    (
        .i_clk_sys   (i_clk_sys),
        .i_nrst      (i_nrst),
        .i_async     ({i_serial_data_in, i_serial_clock, i_chip_select_n}),
        .o_sync      (pins_sync)
    );

    // Reset state leaves on the first clock after release
    always @*
    begin
        next_state = state;
        case (state)
            ST_POR:     next_state = ST_STANDBY;
            ST_STANDBY: if (cs_fall) next_state = ST_ACTIVE;
            ST_ACTIVE:  if (cs_rise) next_state = ST_STANDBY;
            default:    next_state = ST_POR;
        endcase
    end

    // Frame tracking and pin edge history
    always @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state          <= ST_POR;
            cs_q           <= 1'b1;
            sck_q          <= 1'b1;
            o_standby      <= 1'b0;
            o_instr_start  <= 1'b0;
            o_instr_active <= 1'b0;
        end
        else
        begin
            state          <= next_state;
            cs_q           <= cs_s;
            sck_q          <= sck_s;
            o_standby      <= (next_state == ST_STANDBY);
            o_instr_start  <= opens_frame(state, cs_fall);
            o_instr_active <= (next_state == ST_ACTIVE);
        end
    end

    // Clock mode taken from the idle clock level at each accepted select fall
    always @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            o_clock_mode <= `MODE_RESET;
        else if (opens_frame(state, cs_fall))
            o_clock_mode <= sck_s ? `MODE_3 : `MODE_0;
    end

    // Input bits taken only inside a properly opened instruction
    always @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_shift_strobe <= 1'b0;
            o_shift_bit    <= 1'b0;
        end
        else
        begin
            o_shift_strobe <= in_frame(state, cs_s) && sck_rise;
            if (in_frame(state, cs_s) && sck_rise)
                o_shift_bit <= si_s;
        end
    end

    // Output pin released unless the core drives it within an open frame
    always @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_serial_data_out      <= 1'b0;
            o_serial_data_out_oe_n <= 1'b1;
        end
        else if (in_frame(state, cs_s) && i_out_request)
        begin
            o_serial_data_out_oe_n <= 1'b0;
            o_serial_data_out      <= i_out_data;
        end
        else
        begin
            o_serial_data_out_oe_n <= 1'b1;
            o_serial_data_out      <= 1'b0;
        end
    end

    // Startup delay counted from each reset release, restarted by every reset
    always @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            startup_cnt  <= {`STARTUP_CNT_W{1'b0}};
            startup_done <= 1'b0;
        end
        else if (!startup_done)
        begin
            if (startup_cnt == STARTUP_LAST)
                startup_done <= 1'b1;
            else
                startup_cnt <= startup_cnt + 1'b1;
        end
    end

    // Program and erase held off until startup delay has run out
    always @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pe_pending           <= 1'b0;
            o_prog_erase_allowed <= 1'b0;
            o_prog_erase_go      <= 1'b0;
        end
        else
        begin
            o_prog_erase_allowed <= startup_done;
            o_prog_erase_go      <= 1'b0;
            if (i_prog_erase_req && powered_up(state))
                pe_pending <= 1'b1;
            // A request arriving while a pending one launches stays pending
            if (startup_done && (pe_pending || i_prog_erase_req) && powered_up(state))
            begin
                o_prog_erase_go <= 1'b1;
                pe_pending      <= pe_pending && i_prog_erase_req;
            end
        end
    end
endmodule

/* File: tb/flash_por_state_asserts.sv */
// Assertions on the power-up state block ports
module flash_por_state_asserts
#(parameter PROG_ERASE_STARTUP_CYC = 50)
(
    input wire i_clk_sys,
    input wire i_nrst,
    input wire i_chip_select_n,
    input wire i_serial_clock,
    input wire o_serial_data_out_oe_n,
    input wire o_clock_mode,
    input wire o_standby,
    input wire o_instr_start,
    input wire o_prog_erase_allowed
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int P = PROG_ERASE_STARTUP_CYC;
    int cyc;
    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);
    always @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            cyc <= 0;
        else
            cyc <= cyc + 1;
    end
    sequence cs_idle;
        i_chip_select_n [*5];
    endsequence
    a_mode_default: assert property ($rose(i_nrst) |-> o_clock_mode [*3]) else $error("mode");
    a_out_idle: assert property (o_standby |-> o_serial_data_out_oe_n) else $error("oe");
    a_start_gate: assert property (cs_idle |=> !o_instr_start) else $error("start");
    a_mode_pick: assert property (o_instr_start |-> o_clock_mode == $past(i_serial_clock, 4)) else $error("pick");
    a_reset_quiet: assert property (disable iff (1'b0) !i_nrst |-> o_serial_data_out_oe_n) else $error("por");
    a_standby_entry: assert property ($rose(i_nrst) |-> ##[0:1] o_standby) else $error("stby");
    a_pe_delay: assert property ($rose(o_prog_erase_allowed) |-> cyc >= P - 2 && cyc <= P + 2) else $error("pe");
endmodule
bind flash_por_state flash_por_state_asserts #(.PROG_ERASE_STARTUP_CYC(PROG_ERASE_STARTUP_CYC)) chk
(
    .i_clk_sys              (i_clk_sys),
    .i_nrst                 (i_nrst),
    .i_chip_select_n        (i_chip_select_n),
    .i_serial_clock         (i_serial_clock),
    .o_serial_data_out_oe_n (o_serial_data_out_oe_n),
    .o_clock_mode           (o_clock_mode),
    .o_standby              (o_standby),
    .o_instr_start          (o_instr_start),
    .o_prog_erase_allowed   (o_prog_erase_allowed)
);

/* File: tb/flash_host_model.sv */
// Host model driving select, serial clock and data
module flash_host_model
(
    output logic o_cs_n = 1'b1,
    output logic o_sck = 1'b1,
    output logic o_si = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    task automatic xfer(input logic sel, input logic m, input logic [7:0] d);
        o_sck = m;
        #500 o_cs_n = !sel;
        #500;
        for (int i = 7; i >= 0; i--)
        begin
            o_sck = 1'b0;
            o_si = d[i];
            #62.5 o_sck = 1'b1;
            #62.5;
        end
        o_sck = m;
        o_si = !o_si;
        #500 o_cs_n = 1'b1;
        #500;
    endtask
endmodule

/* File: tb/flash_por_state_tb.sv */
// Self-checking bench for the power-up state block
module flash_por_state_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int P = 50;
    logic i_clk_sys = 1'b0, i_nrst = 1'b1, i_prog_erase_req = 1'b0, i_out_request = 1'b1, i_out_data = 1'b1;
    wire i_chip_select_n, i_serial_clock, i_serial_data_in, o_serial_data_out, o_serial_data_out_oe_n;
    wire o_clock_mode, o_standby, o_instr_start, o_instr_active, o_shift_strobe, o_shift_bit;
    wire o_prog_erase_allowed, o_prog_erase_go;
    int num_errors, checked, cyc, s, n, dr;
    logic [7:0] got;
    logic z, q;
    flash_host_model host
    (
        .o_cs_n (i_chip_select_n),
        .o_sck  (i_serial_clock),
        .o_si   (i_serial_data_in)
    );
    flash_por_state #(.PROG_ERASE_STARTUP_CYC(P)) dut
    (
        .i_clk_sys              (i_clk_sys),
        .i_nrst                 (i_nrst),
        .i_chip_select_n        (i_chip_select_n),
        .i_serial_clock         (i_serial_clock),
        .i_serial_data_in       (i_serial_data_in),
        .i_out_request          (i_out_request),
        .i_out_data             (i_out_data),
        .i_prog_erase_req       (i_prog_erase_req),
        .o_serial_data_out      (o_serial_data_out),
        .o_serial_data_out_oe_n (o_serial_data_out_oe_n),
        .o_clock_mode           (o_clock_mode),
        .o_standby              (o_standby),
        .o_instr_start          (o_instr_start),
        .o_instr_active         (o_instr_active),
        .o_shift_strobe         (o_shift_strobe),
        .o_shift_bit            (o_shift_bit),
        .o_prog_erase_allowed   (o_prog_erase_allowed),
        .o_prog_erase_go        (o_prog_erase_go)
    );
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checked++;
        num_errors += seen !== exp;
        if (seen !== exp)
            $display("Error %s expected %h seen %h", what, exp, seen);
    endtask
    task automatic end_of_test;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
        forever #5 i_clk_sys = !i_clk_sys;
    always @(posedge i_clk_sys)
    begin
        cyc <= cyc + 1;
        s <= s + o_instr_start;
        n <= n + o_shift_strobe;
        if (o_shift_strobe)
            got <= {got[6:0], o_shift_bit};
        if (o_instr_active)
            z <= o_serial_data_out_oe_n;
        if (!o_serial_data_out_oe_n)
        begin
            dr <= dr + 1;
            q  <= o_serial_data_out;
        end
        if (cyc == 20000)
        begin
            num_errors++;
            end_of_test;
        end
    end
    task automatic t_startup;
        // Request held back until the startup delay has run out
        @(posedge i_clk_sys) #1;
        chk("allowed", 8'h00, 8'(o_prog_erase_allowed));
        i_prog_erase_req = 1'b1;
        @(posedge i_clk_sys) #1 i_prog_erase_req = 1'b0;
        while (o_prog_erase_go !== 1'b1)
            @(posedge i_clk_sys) #1;
        chk("go", 8'h01, 8'(cyc >= P + 10 && cyc <= P + 16));
    endtask
    task automatic t_frame(input logic m, input logic [7:0] d);
        s = 0;
        n = 0;
        z = 1'b1;
        i_out_data = d[0];
        host.xfer(1'b1, m, d);
        chk("starts", 8'h01, 8'(s));
        chk("bits", d, got);
        chk("count", 8'h08, 8'(n));
        chk("mode", 8'(m), 8'(o_clock_mode));
        chk("oe_n", 8'h00, 8'(z));
        chk("data_out", 8'(d[0]), 8'(q));
        chk("standby", 8'h01, 8'(o_standby));
    endtask
    task automatic t_ignored(input logic rst);
        @(posedge i_clk_sys) #1 i_nrst = !rst;
        s = 0;
        n = 0;
        dr = 0;
        host.xfer(rst, 1'b0, 8'h96);
        chk("starts", 8'h00, 8'(s));
        chk("count", 8'h00, 8'(n));
        chk("driven", 8'h00, 8'(dr != 0));
        chk("oe_n", 8'h01, 8'(o_serial_data_out_oe_n));
        chk("mode", 8'(rst), 8'(o_clock_mode));
        @(posedge i_clk_sys) #1 i_nrst = 1'b1;
    endtask
    initial
    begin
        #1 i_nrst = 1'b0;
        repeat (12) @(posedge i_clk_sys);
        #1 i_nrst = 1'b1;
        t_startup();
        #70000;
        t_frame(1'b1, 8'ha5);
        t_frame(1'b0, 8'h3c);
        t_ignored(1'b0);
        t_ignored(1'b1);
        t_frame(1'b1, 8'h5a);
        end_of_test;
    end
endmodule
